//--- design/iem_interrupt_enable_mask.sv
// Interrupt enable mask, flag register and host interrupt line behind an APB slave.
`timescale 1ns/1ps
module iem_interrupt_enable_mask
   import iem_pkg::*;
#(
   parameter int TALLY_COUNT = 3
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire iem_events_t coreEvents,
   input wire logic [TALLY_COUNT-1:0] tallyMsb,
   input wire logic enterReset,
   input wire logic startCommand,
   output logic hostIrq
);

   // Elaboration check on the number of tally counters.
   if (TALLY_COUNT < 1 || TALLY_COUNT > 8) begin : gBadTally
      $error("TALLY_COUNT must be 1 to 8");
   end

   logic [7:0] interrupt_enable_mask_r;
   logic [7:0] interrupt_flag_register_r;
   logic [7:0] flagSet;
   logic [TALLY_COUNT-1:0] tallyMsbPrev_r;
   logic tallyRise;
   logic accessCycle;
   logic wrMask;
   logic wrFlag;
   logic [7:0] pendingVec;
   logic rdErr;
   logic [31:0] rdData;

   // Decode one address against a register offset.
   function automatic logic hitOfs(input logic [11:0] a, input logic [11:0] ofs);
      hitOfs = (a == ofs);
   endfunction

   // Zero-wait-state slave: the access phase completes in its first cycle.
   assign accessCycle = psel && penable;
   assign wrMask = accessCycle && pwrite && hitOfs(paddr, IEM_MASK_OFS);
   assign wrFlag = accessCycle && pwrite && hitOfs(paddr, IEM_FLAG_OFS);

   // A tally flag rises on a 0-to-1 change of any counter MSB, so a held MSB cannot re-set a cleared flag.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         tallyMsbPrev_r <= '0;
      end else begin
         tallyMsbPrev_r <= tallyMsb;
      end
   end
   assign tallyRise = |(tallyMsb & ~tallyMsbPrev_r);

   // Hardware set vector; the set does not look at the mask at all.
   always_comb begin
      flagSet = 8'h00;
      flagSet[RX_OK_BIT] = coreEvents.rxOk;
      flagSet[TX_OK_BIT] = coreEvents.txOk;
      flagSet[RX_FAULT_BIT] = coreEvents.rxFault;
      flagSet[TX_FAULT_BIT] = coreEvents.txFault;
      flagSet[RING_FULL_BIT] = coreEvents.ringFull;
      flagSet[TALLY_OVF_BIT] = tallyRise;
      flagSet[HOST_DONE_BIT] = coreEvents.hostDone;
   end

   // Mask register: bit 7 is never stored, so it always reads zero.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         interrupt_enable_mask_r <= IEM_MASK_RST;
      end else if (wrMask) begin
         interrupt_enable_mask_r <= pwdata[7:0] & IEM_MASK_WMASK;
      end
   end

   // Flag register: write one to clear, and a set in the same cycle wins over the clear.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         interrupt_flag_register_r <= IEM_FLAG_RST;
      end else begin
         interrupt_flag_register_r[6:0] <= (interrupt_flag_register_r[6:0]
            & ~(wrFlag ? pwdata[6:0] & IEM_FLAG_WMASK[6:0] : 7'h00)) | flagSet[6:0];
         // Reset status follows the core only; software writes cannot touch it.
         if (enterReset) begin
            interrupt_flag_register_r[RESET_STAT_BIT] <= 1'b1;
         end else if (startCommand) begin
            interrupt_flag_register_r[RESET_STAT_BIT] <= 1'b0;
         end
      end
   end

   // Per-source gating; the reset status bit is excluded by the mask's bit 7 being zero.
   assign pendingVec = interrupt_flag_register_r & interrupt_enable_mask_r & IEM_MASK_WMASK;

   // Interrupt line is registered so the output comes straight from a flip-flop.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         hostIrq <= 1'b0;
      end else begin
         hostIrq <= |pendingVec;
      end
   end

   // Read mux; unmapped addresses answer with an error and zero data.
   always_comb begin
      rdData = 32'h0000_0000;
      rdErr = 1'b0;
      if (hitOfs(paddr, IEM_MASK_OFS)) begin
         rdData = {24'h000000, interrupt_enable_mask_r};
      end else if (hitOfs(paddr, IEM_FLAG_OFS)) begin
         rdData = {24'h000000, interrupt_flag_register_r};
      end else if (hitOfs(paddr, IEM_INTSTAT_OFS)) begin
         rdData = {24'h000000, pendingVec};
      end else begin
         rdErr = 1'b1;
      end
   end

   // Response registers: pready rises in the cycle after setup, giving one access cycle.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         prdata <= (psel && !penable && !pwrite) ? rdData : 32'h0000_0000;
         pslverr <= psel && !penable && rdErr;
      end
   end

   // Assertions guarding the mask and interrupt behaviour.
   // The checks fall into nine groups.
   // The first group proves that an enabled flag always reaches the interrupt line one edge later.
   // The second group proves that a cleared enable bit keeps its source out of the pending vector.
   // The fourth and fifth groups cover the flag register itself: hardware sets, software clears and the race between them.
   // The last group watches the bus answer, since the master counts on a single access cycle.
   // Every check except mask_reset_zero_a is disabled during reset, because the flops are held at constants there.
   // The reset status bit gets checks of its own, because it follows the core and never the bus.
   // A user must know that the interrupt line lags the flag by one edge.
   // That lag was accepted so that the line comes straight from a flip-flop and cannot glitch.
   // The tally flag reacts to a rising counter MSB only.
   // A counter that keeps its MSB set therefore raises one interrupt, not a stream of them.
   logic [7:0] pendPast;
   logic [7:0] maskWrVal;
   assign pendPast = interrupt_flag_register_r & interrupt_enable_mask_r;
   assign maskWrVal = pwdata[7:0] & IEM_MASK_WMASK;

   // Enabled flags raise the line on the next edge.
   rx_fault_gate_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      (interrupt_flag_register_r[RX_FAULT_BIT] && interrupt_enable_mask_r[RX_FAULT_BIT]) |=> hostIrq)
      else $error("Enabled receive fault did not raise interrupt");
   tx_fault_gate_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      (interrupt_flag_register_r[TX_FAULT_BIT] && interrupt_enable_mask_r[TX_FAULT_BIT]) |=> hostIrq)
      else $error("Enabled transmit fault did not raise interrupt");
   ring_full_gate_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      (interrupt_flag_register_r[RING_FULL_BIT] && interrupt_enable_mask_r[RING_FULL_BIT]) |=> hostIrq)
      else $error("Enabled ring full did not raise interrupt");
   tally_gate_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      (interrupt_flag_register_r[TALLY_OVF_BIT] && interrupt_enable_mask_r[TALLY_OVF_BIT]) |=> hostIrq)
      else $error("Enabled tally overflow did not raise interrupt");
   host_done_gate_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      (interrupt_flag_register_r[HOST_DONE_BIT] && interrupt_enable_mask_r[HOST_DONE_BIT]) |=> hostIrq)
      else $error("Enabled transfer done did not raise interrupt");
   rx_ok_gate_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      (interrupt_flag_register_r[RX_OK_BIT] && interrupt_enable_mask_r[RX_OK_BIT]) |=> hostIrq)
      else $error("Enabled receive done did not raise interrupt");
   tx_ok_gate_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      (interrupt_flag_register_r[TX_OK_BIT] && interrupt_enable_mask_r[TX_OK_BIT]) |=> hostIrq)
      else $error("Enabled transmit done did not raise interrupt");

   // A cleared enable bit keeps its source out of the pending vector.
   // These fail if the gating term is dropped from the pending logic.
   rx_fault_block_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      !interrupt_enable_mask_r[RX_FAULT_BIT] |-> !pendingVec[RX_FAULT_BIT])
      else $error("Masked receive fault is pending");
   tx_fault_block_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      !interrupt_enable_mask_r[TX_FAULT_BIT] |-> !pendingVec[TX_FAULT_BIT])
      else $error("Masked transmit fault is pending");
   ring_full_block_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      !interrupt_enable_mask_r[RING_FULL_BIT] |-> !pendingVec[RING_FULL_BIT])
      else $error("Masked ring full is pending");
   tally_block_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      !interrupt_enable_mask_r[TALLY_OVF_BIT] |-> !pendingVec[TALLY_OVF_BIT])
      else $error("Masked tally overflow is pending");
   host_done_block_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      !interrupt_enable_mask_r[HOST_DONE_BIT] |-> !pendingVec[HOST_DONE_BIT])
      else $error("Masked transfer done is pending");
   rx_ok_block_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      !interrupt_enable_mask_r[RX_OK_BIT] |-> !pendingVec[RX_OK_BIT])
      else $error("Masked receive done is pending");
   tx_ok_block_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      !interrupt_enable_mask_r[TX_OK_BIT] |-> !pendingVec[TX_OK_BIT])
      else $error("Masked transmit done is pending");

   // The reserved mask bit stays clear, and the line follows the pending vector both ways.
   mask_bit7_zero_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      !interrupt_enable_mask_r[7])
      else $error("Reserved mask bit became set");
   irq_cause_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      hostIrq |-> $past(|pendPast[6:0]))
      else $error("Interrupt raised without enabled flag");
   irq_drop_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      !(|pendingVec) |=> !hostIrq)
      else $error("Interrupt stayed high with nothing pending");

   // Every event sets its flag whatever the mask holds.
   // A missed set here would hide the event from polling software.
   masked_flag_sets_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      coreEvents.rxFault |=> interrupt_flag_register_r[RX_FAULT_BIT])
      else $error("Flag not set while masked");
   tx_fault_sets_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      coreEvents.txFault |=> interrupt_flag_register_r[TX_FAULT_BIT])
      else $error("Transmit fault flag not set");
   ring_full_sets_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      coreEvents.ringFull |=> interrupt_flag_register_r[RING_FULL_BIT])
      else $error("Ring full flag not set");
   host_done_sets_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      coreEvents.hostDone |=> interrupt_flag_register_r[HOST_DONE_BIT])
      else $error("Transfer done flag not set");
   rx_ok_sets_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      coreEvents.rxOk |=> interrupt_flag_register_r[RX_OK_BIT])
      else $error("Receive done flag not set");
   tx_ok_sets_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      coreEvents.txOk |=> interrupt_flag_register_r[TX_OK_BIT])
      else $error("Transmit done flag not set");

   // Software clears by writing one; a set in the same cycle wins.
   // Losing that race would silently drop an event.
   flag_set_wins_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      (wrFlag && pwdata[RX_FAULT_BIT] && coreEvents.rxFault) |=> interrupt_flag_register_r[RX_FAULT_BIT])
      else $error("Clear beat a simultaneous set");
   flag_w1c_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      (wrFlag && pwdata[TX_FAULT_BIT] && !coreEvents.txFault) |=> !interrupt_flag_register_r[TX_FAULT_BIT])
      else $error("Write one did not clear flag");

   // Mask writes land as written, minus the reserved bit, and nothing else moves the mask.
   mask_write_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      wrMask |=> interrupt_enable_mask_r == $past(maskWrVal))
      else $error("Mask write did not land");
   mask_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      !wrMask |=> $stable(interrupt_enable_mask_r))
      else $error("Mask changed without a write");
   mask_reset_zero_a: assert property (@(posedge sys_clk)
      $rose(nrst) |-> interrupt_enable_mask_r == IEM_MASK_RST)
      else $error("Mask not zero after reset");

   // Reset status follows the core controls only.
   // Entering reset wins over a start in the same cycle.
   reset_stat_write_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      (wrFlag && !enterReset && !startCommand) |=> $stable(interrupt_flag_register_r[RESET_STAT_BIT]))
      else $error("Software write changed reset status");
   reset_stat_set_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      enterReset |=> interrupt_flag_register_r[RESET_STAT_BIT])
      else $error("Reset entry did not set status");
   reset_stat_clr_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      (startCommand && !enterReset) |=> !interrupt_flag_register_r[RESET_STAT_BIT])
      else $error("Start did not clear reset status");

   // The tally flag sets on a rising MSB and a held MSB cannot undo a clear.
   tally_set_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      ($rose(|tallyMsb) && tallyMsbPrev_r == '0) |=> interrupt_flag_register_r[TALLY_OVF_BIT])
      else $error("Tally MSB did not set overflow flag");
   tally_held_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      (tallyMsb == tallyMsbPrev_r && wrFlag && pwdata[TALLY_OVF_BIT]) |=> !interrupt_flag_register_r[TALLY_OVF_BIT])
      else $error("Held tally MSB set the flag again");

   // Bus answer: one ready pulse per transfer, error and data only alongside it.
   // The master relies on the data being zero outside the answer cycle.
   ready_pulse_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      pready |=> !pready)
      else $error("Ready stayed high for two cycles");
   err_with_ready_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      pslverr |-> pready)
      else $error("Error answer without ready");
   rdata_idle_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      !pready |-> prdata == 32'h0000_0000)
      else $error("Read data shown outside answer cycle");

   // Main scenarios that the bench is expected to reach.
   irq_seen_c: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(hostIrq));
   mask_write_c: cover property (@(posedge sys_clk) disable iff (!nrst) wrMask && pwdata[6:2] != 5'h00);
   clear_race_c: cover property (@(posedge sys_clk) disable iff (!nrst) wrFlag && |flagSet[6:0]);
   masked_event_c: cover property (@(posedge sys_clk) disable iff (!nrst)
      coreEvents.txFault && !interrupt_enable_mask_r[TX_FAULT_BIT]);
   reset_stat_c: cover property (@(posedge sys_clk) disable iff (!nrst)
      $rose(interrupt_flag_register_r[RESET_STAT_BIT]));

endmodule

//--- include/iem_pkg.sv
// Package holding register map, bit positions and carrier types for the interrupt enable mask block.
// Contract
// - Receive-error enable D2 gates receive-error flag.
// - Transmit-error enable D3 gates transmit-error flag.
// - Ring-full enable D4 gates overwrite-warning flag.
// - Tally-overflow enable D5 gates counter-overflow flag.
// - Host-transfer-done enable D6 gates completion flag.
// - Interrupt when any flag and enable set.
// - Mask resets to all zeros.
// - Reset status bit 7 never interrupts, unwritable.
// - Tally flag sets on any counter MSB.
package iem_pkg;

   // Register byte offsets on the APB bus.
   localparam logic [11:0] IEM_MASK_OFS = 12'h000;
   localparam logic [11:0] IEM_FLAG_OFS = 12'h004;
   localparam logic [11:0] IEM_INTSTAT_OFS = 12'h008;

   // Bit positions shared by the mask and the flag register.
   localparam int RX_OK_BIT = 0;
   localparam int TX_OK_BIT = 1;
   localparam int RX_FAULT_BIT = 2;
   localparam int TX_FAULT_BIT = 3;
   localparam int RING_FULL_BIT = 4;
   localparam int TALLY_OVF_BIT = 5;
   localparam int HOST_DONE_BIT = 6;
   localparam int RESET_STAT_BIT = 7;

   // Reset values and the writable parts of the mask and the flag register.
   localparam logic [7:0] IEM_MASK_RST = 8'h00;
   localparam logic [7:0] IEM_FLAG_RST = 8'h80;
   localparam logic [7:0] IEM_MASK_WMASK = 8'h7F;
   localparam logic [7:0] IEM_FLAG_WMASK = 8'h7F;

   // Event pulses coming from the controller core.
   typedef struct packed {
      logic hostDone;
      logic ringFull;
      logic txFault;
      logic rxFault;
      logic txOk;
      logic rxOk;
   } iem_events_t;

endpackage

//--- sim/iem_host_model.sv
// Host interrupt input model that remembers whether the line was seen high.
`timescale 1ns/1ps
module iem_host_model (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic clrSeen,
   input wire logic hostIrq,
   output logic irqSeen
);
   // Sticky capture, so a one-cycle glitch on the level line is missed only while clrSeen is high.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         irqSeen <= 1'h0;
      end else begin
         irqSeen <= !clrSeen && (irqSeen || hostIrq);
      end
   end
endmodule

//--- sim/testbench.sv
// Self-checking testbench for the interrupt enable mask block.
`timescale 1ns/1ps
module testbench;
   import iem_pkg::*;
   logic sys_clk = 1'h0;
   logic nrst = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   iem_events_t coreEvents = '0;
   logic [2:0] tallyMsb = 3'h0;
   logic enterReset = 1'h0;
   logic startCommand = 1'h0;
   logic hostIrq;
   logic irqSeen;
   logic clrSeen = 1'h0;
   logic [31:0] rd;
   logic err;
   int err_total = 0;
   int check_count = 0;
   // Free-running 100 MHz clock.
   always #5 sys_clk = ~sys_clk;
   iem_interrupt_enable_mask #(.TALLY_COUNT(3)) dut_u (.sys_clk(sys_clk), .nrst(nrst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .coreEvents(coreEvents), .tallyMsb(tallyMsb), .enterReset(enterReset),
      .startCommand(startCommand), .hostIrq(hostIrq));
   iem_host_model host_u (.sys_clk(sys_clk), .nrst(nrst), .clrSeen(clrSeen), .hostIrq(hostIrq),
      .irqSeen(irqSeen));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run();
      if (err_total == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // One APB transfer; entered right after an edge, the request holds until pready is sampled.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'h1;
      @(posedge sys_clk);
      while (pready !== 1'h1) begin
         @(posedge sys_clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge sys_clk);
   endtask
   // Watchdog sized well beyond the whole sequence.
   initial begin
      repeat (3000) @(posedge sys_clk);
      err_total++;
      complete_run();
   end
   // Register checks, then every source masked and unmasked in turn.
   initial begin
      repeat (4) @(posedge sys_clk);
      nrst <= 1'h1;
      apb(1'h0, IEM_MASK_OFS, 32'h0);
      check("mask reset", rd, 32'h0);
      apb(1'h0, IEM_FLAG_OFS, 32'h0);
      check("flag reset", rd, 32'h80);
      apb(1'h1, IEM_MASK_OFS, 32'hFF);
      apb(1'h1, IEM_FLAG_OFS, 32'hFF);
      apb(1'h0, IEM_MASK_OFS, 32'h0);
      check("mask bit7", rd, 32'h7F);
      apb(1'h0, IEM_FLAG_OFS, 32'h0);
      check("flag bit7", rd, 32'h80);
      check("irq idle", {31'h0, hostIrq}, 32'h0);
      apb(1'h1, IEM_MASK_OFS, 32'h0);
      for (int b = 0; b < 7; b++) begin
         clrSeen <= 1'h1;
         if (b == 5) tallyMsb <= 3'h4;
         else coreEvents <= iem_events_t'(b == 6 ? 6'h20 : 6'h01 << b);
         @(posedge sys_clk);
         clrSeen <= 1'h0;
         coreEvents <= '0;
         tallyMsb <= 3'h0;
         repeat (3) @(posedge sys_clk);
         check("masked irq", {31'h0, irqSeen}, 32'h0);
         apb(1'h0, IEM_FLAG_OFS, 32'h0);
         check("flag set", rd, 32'h80 | (32'h1 << b));
         apb(1'h1, IEM_MASK_OFS, 32'h1 << b);
         repeat (2) @(posedge sys_clk);
         check("irq on", {31'h0, hostIrq}, 32'h1);
         apb(1'h0, IEM_INTSTAT_OFS, 32'h0);
         check("pending", rd, 32'h1 << b);
         apb(1'h1, IEM_FLAG_OFS, 32'h1 << b);
         repeat (2) @(posedge sys_clk);
         check("irq off", {31'h0, hostIrq}, 32'h0);
         apb(1'h1, IEM_MASK_OFS, 32'h0);
      end
      startCommand <= 1'h1;
      @(posedge sys_clk);
      startCommand <= 1'h0;
      apb(1'h0, IEM_FLAG_OFS, 32'h0);
      check("flag start", rd, 32'h0);
      apb(1'h1, IEM_MASK_OFS, 32'hFF);
      enterReset <= 1'h1;
      @(posedge sys_clk);
      enterReset <= 1'h0;
      clrSeen <= 1'h1;
      @(posedge sys_clk);
      clrSeen <= 1'h0;
      apb(1'h0, IEM_FLAG_OFS, 32'h0);
      check("flag entered", rd, 32'h80);
      check("irq status", {31'h0, irqSeen}, 32'h0);
      apb(1'h1, 12'h00C, 32'hFF);
      check("unmapped err", {31'h0, err}, 32'h1);
      apb(1'h0, 12'h00C, 32'h0);
      check("unmapped rd", rd, 32'h0);
      complete_run();
   end
endmodule
